// *** include/sac_pkg.sv ***
package sac_pkg;

  // ***********************************************************
  // Register map (byte addresses, APB, one word each)
  // ***********************************************************
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] CH_CFG_OFS = 8'h04;
  localparam logic [7:0] TRIG_SRC_OFS = 8'h08;
  localparam logic [7:0] DELAY_OFS = 8'h0C;
  localparam logic [7:0] LENGTH_OFS = 8'h10;
  localparam logic [7:0] SEG_COUNT_OFS = 8'h14;
  localparam logic [7:0] AVG_COUNT_OFS = 8'h18;
  localparam logic [7:0] TIME_BASE_OFS = 8'h1C;
  localparam logic [7:0] STATUS_OFS = 8'h20;
  localparam logic [7:0] DATA_OFS = 8'h24;
  localparam logic [7:0] TRIG_STATE_OFS = 8'h28;

  // ***********************************************************
  // Field positions
  // ***********************************************************
  localparam int CTRL_ACQ_EN_BIT = 0;
  localparam int CTRL_SINGLE_BIT = 1;
  localparam int CTRL_TRIG_MODE_BIT = 2;
  localparam int CTRL_AVG_EN_BIT = 3;
  localparam int CTRL_SEG_EN_BIT = 4;
  localparam int CTRL_SW_TRIG_BIT = 5;
  localparam int CH_CFG_STRIDE = 8;
  localparam int CH_CFG_EN_BIT = 7;
  localparam int STATUS_BUSY_BIT = 0;
  localparam int STATUS_DATA_BIT = 1;
  localparam int STATUS_SEG_POS = 16;
  localparam int TRIG_STATE_B_POS = 2;

  // ***********************************************************
  // Reset values
  // ***********************************************************
  localparam logic [15:0] LENGTH_RST = 16'h0010;
  localparam logic [15:0] SEG_COUNT_RST = 16'h0001;
  localparam logic [15:0] AVG_COUNT_RST = 16'h0001;

  // ***********************************************************
  // Selector codes
  // ***********************************************************
  localparam logic [5:0] SEL_ANALYZER = 6'h00;
  localparam logic [5:0] SEL_GEN_FIRST = 6'h30;
  localparam logic [5:0] SEL_GEN_LAST = 6'h35;
  localparam logic [10:0] TRG_EXT_A = 11'h000;
  localparam logic [10:0] TRG_EXT_B = 11'h001;
  localparam logic [10:0] TRG_INTERNAL = 11'h008;
  localparam logic [10:0] TRG_SEQ_OUT_1 = 11'h020;
  localparam logic [10:0] TRG_SEQ_OUT_2 = 11'h024;
  localparam logic [10:0] TRG_SEQ_MON = 11'h040;
  localparam logic [10:0] TRG_SOFTWARE = 11'h400;
  localparam logic [1:0] TIME_BASE_2GHZ = 2'h0;

  // ***********************************************************
  // Timing
  // ***********************************************************
  localparam int DELAY_STEP_NS = 2;
  localparam int CLK_HZ = 40000000;
  localparam int TRIG_WIN_MS = 100;
  localparam int TRIG_WIN_CYCLES = TRIG_WIN_MS * (CLK_HZ / 1000);

  typedef struct packed {
    logic seg_en;
    logic avg_en;
    logic trig_mode;
    logic single;
    logic acq_en;
  } sac_ctrl_t;

endpackage : sac_pkg

// *** core/sac_top.sv ***
// Behaviour
// - Averaging accumulates a software-programmed number of measurements.
// - Averaging only applies while averaging enable is set.
// - A channel records samples only while its own enable is set.
// - Input select 0 is analyzer input; 48..53 pick generator outputs 1..6.
// - Acquisition enable clears itself once the pending shot is acquired.
// - Each shot records the programmed number of samples.
// - Segmented capture splits memory; shot length limited to memory/segments.
// - Segmented shots go to successive segments with minimal dead time.
// - Single mode takes exactly one shot and then stops.
// - Time base code 0 means 2 GHz sampling.
// - Trigger source codes 0,1,8,32,36,64,1024 are decoded.
// - Capture window offset from trigger by delay in 2 ns steps.
// - Negative delay stores pre-trigger samples from a running history.
// - Trigger mode 0 captures continuously; 1 captures on each trigger. Here mode 0 starts each shot without a trigger and stops once acq_en clears.
// - Captured samples of enabled channels are readable after capture.
// - Trigger inputs report 1 low, 2 high, 3 both over 100 ms.
//
// The implementer's own choices: the APB register port and the address map.

// ***********************************************************
// Output buffer
// ***********************************************************
module sac_fifo #(
  parameter int W = 32,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } sac_fifo_st_t;
  sac_fifo_st_t s_reg;
  sac_fifo_st_t s_next;
  logic push;
  logic pop;

  assign in_ready = (s_reg.cnt != (AW+1)'(DEPTH));
  assign out_valid = (s_reg.cnt != '0);
  assign out_data = s_reg.mem[s_reg.rp];

  always_comb begin
    s_next = s_reg;
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    if (push) begin
      s_next.mem[s_reg.wp] = in_data;
      s_next.wp = (s_reg.wp == AW'(DEPTH - 1)) ? '0 : s_reg.wp + 1'b1;
    end
    if (pop) begin
      s_next.rp = (s_reg.rp == AW'(DEPTH - 1)) ? '0 : s_reg.rp + 1'b1;
    end
    if (push && !pop) begin
      s_next.cnt = s_reg.cnt + 1'b1;
    end else if (pop && !push) begin
      s_next.cnt = s_reg.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end
endmodule : sac_fifo

// ***********************************************************
// Acquisition controller
// ***********************************************************
module sac_top #(
  parameter int N_CH = 2,
  parameter int SAMPLE_W = 16,
  parameter int MEM_DEPTH = 32,
  parameter int PRE_DEPTH = 16,
  parameter int FIFO_DEPTH = 8,
  parameter int WINDOW_CYCLES = sac_pkg::TRIG_WIN_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [SAMPLE_W-1:0] analyzer_signal_input,
  input wire logic [5:0][SAMPLE_W-1:0] generator_output,
  input wire logic ext_trigger_a,
  input wire logic ext_trigger_b,
  input wire logic internal_trigger,
  input wire logic sequencer_trigger_out_1,
  input wire logic sequencer_trigger_out_2,
  input wire logic sequencer_monitor_trigger,
  output logic acq_active
);
  localparam int PW = $clog2(PRE_DEPTH);
  localparam int MW = $clog2(MEM_DEPTH);
  localparam int CW = (N_CH > 1) ? $clog2(N_CH) : 1;

  typedef enum logic [2:0] {
    PH_IDLE,
    PH_ARM,
    PH_DELAY,
    PH_RECORD,
    PH_UNLOAD
  } sac_phase_t;

  typedef struct packed {
    sac_pkg::sac_ctrl_t ctrl;
    logic [N_CH-1:0] ch_en;
    logic [N_CH-1:0][5:0] ch_sel;
    logic [10:0] trig_src;
    logic [15:0] delay;
    logic [15:0] length;
    logic [15:0] seg_count;
    logic [15:0] avg_count;
    logic [1:0] time_base;
    sac_phase_t ph;
    logic trig_prev;
    logic sw_trig;
    logic [15:0] cnt;
    logic [15:0] seg_idx;
    logic [15:0] avg_idx;
    logic [15:0] words;
    logic [15:0] rd_idx;
    logic [CW-1:0] rd_ch;
    logic [PW-1:0] pre_wp;
    logic [PRE_DEPTH-1:0][N_CH-1:0][SAMPLE_W-1:0] pre_mem;
    logic [N_CH-1:0][MEM_DEPTH-1:0][31:0] acc;
    logic [31:0] win_cnt;
    logic [1:0] seen_a;
    logic [1:0] seen_b;
    logic [1:0] stat_a;
    logic [1:0] stat_b;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } sac_state_t;

  sac_state_t s_reg;
  sac_state_t s_next;
  logic trig_cur;
  logic [N_CH-1:0][SAMPLE_W-1:0] live;
  logic [N_CH-1:0][SAMPLE_W-1:0] past;
  logic [PW-1:0] lag;
  logic [15:0] seg_div;
  logic [15:0] eff_len;
  logic [15:0] last_seg;
  logic [MW-1:0] wr_addr;
  logic [31:0] smp;
  logic [31:0] rd_mux;
  logic addr_ok;
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic [31:0] fifo_in_data;
  logic fifo_out_valid;
  logic fifo_pop;
  logic [31:0] fifo_out_data;

  function automatic logic [SAMPLE_W-1:0] pick_input(
    input logic [5:0] code,
    input logic [SAMPLE_W-1:0] ana,
    input logic [5:0][SAMPLE_W-1:0] gen
  );
    logic [5:0] k;
    k = code - sac_pkg::SEL_GEN_FIRST;
    if (code == sac_pkg::SEL_ANALYZER) begin
      return ana;
    end else if (code >= sac_pkg::SEL_GEN_FIRST &&
                 code <= sac_pkg::SEL_GEN_LAST) begin
      return gen[k[2:0]];
    end
    return '0;
  endfunction : pick_input

  function automatic logic [1:0] seen_update(
    input logic [1:0] seen,
    input logic lvl
  );
    return seen | (lvl ? 2'h2 : 2'h1);
  endfunction : seen_update

  sac_fifo #(
    .W(32),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(ref_clk),
    .rstn(rstn),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in_data),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_out_data)
  );

  assign prdata = s_reg.prdata;
  assign pready = s_reg.pready;
  assign pslverr = s_reg.pslverr;
  assign acq_active = s_reg.ctrl.acq_en;

  always_comb begin
    s_next = s_reg;
    fifo_in_valid = 1'b0;
    fifo_in_data = '0;
    fifo_pop = 1'b0;
    smp = '0;
    s_next.sw_trig = 1'b0;
    // ***********************************************************
    // Trigger selection and edge detect
    // ***********************************************************
    case (s_reg.trig_src)
      sac_pkg::TRG_EXT_A: trig_cur = ext_trigger_a;
      sac_pkg::TRG_EXT_B: trig_cur = ext_trigger_b;
      sac_pkg::TRG_INTERNAL: trig_cur = internal_trigger;
      sac_pkg::TRG_SEQ_OUT_1: trig_cur = sequencer_trigger_out_1;
      sac_pkg::TRG_SEQ_OUT_2: trig_cur = sequencer_trigger_out_2;
      sac_pkg::TRG_SEQ_MON: trig_cur = sequencer_monitor_trigger;
      sac_pkg::TRG_SOFTWARE: trig_cur = s_reg.sw_trig;
      default: trig_cur = 1'b0;
    endcase
    s_next.trig_prev = trig_cur;
    // ***********************************************************
    // Input routing and pre-trigger history
    // ***********************************************************
    // One sample per clock, each sample one 2 ns step of the time base
    lag = s_reg.delay[15] ? PW'(-s_reg.delay) : '0;
    for (int c = 0; c < N_CH; c++) begin
      live[c] = pick_input(s_reg.ch_sel[c], analyzer_signal_input,
                           generator_output);
      past[c] = s_reg.pre_mem[s_reg.pre_wp - lag][c];
      s_next.pre_mem[s_reg.pre_wp][c] = live[c];
    end
    s_next.pre_wp = s_reg.pre_wp + 1'b1;
    // ***********************************************************
    // Shot geometry
    // ***********************************************************
    seg_div = (s_reg.ctrl.seg_en && s_reg.seg_count != '0) ?
              s_reg.seg_count : 16'h0001;
    eff_len = 16'(MEM_DEPTH) / seg_div;
    if (s_reg.length < eff_len) begin
      eff_len = s_reg.length;
    end
    if (eff_len == '0) begin
      eff_len = 16'h0001;
    end
    last_seg = (s_reg.ctrl.seg_en && !s_reg.ctrl.single) ?
               seg_div - 1'b1 : '0;
    wr_addr = MW'(s_reg.seg_idx * eff_len + s_reg.cnt);
    // ***********************************************************
    // Acquisition sequence
    // ***********************************************************
    case (s_reg.ph)
      PH_IDLE: begin
        s_next.seg_idx = '0;
        s_next.avg_idx = '0;
        s_next.cnt = '0;
        if (s_reg.ctrl.acq_en) begin
          s_next.ph = PH_ARM;
        end
      end
      PH_ARM: begin
        s_next.cnt = '0;
        if (!s_reg.ctrl.acq_en) begin
          s_next.ph = PH_IDLE;
        end else if (!s_reg.ctrl.trig_mode ||
                     (trig_cur && !s_reg.trig_prev)) begin
          s_next.ph = (!s_reg.delay[15] && s_reg.delay != '0) ?
                      PH_DELAY : PH_RECORD;
        end
      end
      PH_DELAY: begin
        s_next.cnt = s_reg.cnt + 1'b1;
        if (s_reg.cnt == s_reg.delay - 1'b1) begin
          s_next.cnt = '0;
          s_next.ph = PH_RECORD;
        end
      end
      PH_RECORD: begin
        for (int c = 0; c < N_CH; c++) begin
          smp = 32'(signed'(s_reg.delay[15] ? past[c] : live[c]));
          if (s_reg.ch_en[c]) begin
            s_next.acc[c][wr_addr] = (s_reg.avg_idx == '0) ? smp :
                                     s_reg.acc[c][wr_addr] + smp;
          end
        end
        s_next.cnt = s_reg.cnt + 1'b1;
        if (s_reg.cnt == eff_len - 1'b1) begin
          s_next.cnt = '0;
          s_next.ph = PH_ARM;
          if (s_reg.ctrl.avg_en &&
              s_reg.avg_idx + 1'b1 < s_reg.avg_count) begin
            s_next.avg_idx = s_reg.avg_idx + 1'b1;
          end else begin
            s_next.avg_idx = '0;
            s_next.seg_idx = s_reg.seg_idx + 1'b1;
            if (s_reg.seg_idx == last_seg) begin
              s_next.words = (s_reg.seg_idx + 1'b1) * eff_len;
              s_next.rd_idx = '0;
              s_next.rd_ch = '0;
              s_next.ctrl.acq_en = 1'b0;
              s_next.ph = PH_UNLOAD;
            end
          end
        end
      end
      PH_UNLOAD: begin
        if (!s_reg.ch_en[s_reg.rd_ch] || s_reg.rd_idx == s_reg.words) begin
          s_next.rd_idx = '0;
          s_next.rd_ch = s_reg.rd_ch + 1'b1;
          if (s_reg.rd_ch == CW'(N_CH - 1)) begin
            s_next.ph = PH_IDLE;
          end
        end else begin
          fifo_in_valid = 1'b1;
          fifo_in_data = s_reg.acc[s_reg.rd_ch][MW'(s_reg.rd_idx)];
          if (s_reg.ctrl.avg_en && s_reg.avg_count > 16'h0001) begin
            fifo_in_data = 32'(signed'(fifo_in_data) /
                               signed'({16'h0000, s_reg.avg_count}));
          end
          if (fifo_in_ready) begin
            s_next.rd_idx = s_reg.rd_idx + 1'b1;
          end
        end
      end
      default: begin
        s_next.ph = PH_IDLE;
      end
    endcase
    // ***********************************************************
    // Trigger input level report
    // ***********************************************************
    s_next.seen_a = seen_update(s_reg.seen_a, ext_trigger_a);
    s_next.seen_b = seen_update(s_reg.seen_b, ext_trigger_b);
    s_next.win_cnt = s_reg.win_cnt + 1'b1;
    if (s_reg.win_cnt == 32'(WINDOW_CYCLES - 1)) begin
      s_next.win_cnt = '0;
      s_next.stat_a = s_next.seen_a;
      s_next.stat_b = s_next.seen_b;
      s_next.seen_a = '0;
      s_next.seen_b = '0;
    end
    // ***********************************************************
    // APB slave
    // ***********************************************************
    addr_ok = 1'b1;
    rd_mux = '0;
    case (paddr)
      sac_pkg::CTRL_OFS: begin
        rd_mux[4:0] = s_reg.ctrl;
      end
      sac_pkg::CH_CFG_OFS: begin
        for (int c = 0; c < N_CH; c++) begin
          rd_mux[c*sac_pkg::CH_CFG_STRIDE +: 6] = s_reg.ch_sel[c];
          rd_mux[c*sac_pkg::CH_CFG_STRIDE + sac_pkg::CH_CFG_EN_BIT] =
            s_reg.ch_en[c];
        end
      end
      sac_pkg::TRIG_SRC_OFS: rd_mux[10:0] = s_reg.trig_src;
      sac_pkg::DELAY_OFS: rd_mux = 32'(signed'(s_reg.delay));
      sac_pkg::LENGTH_OFS: rd_mux[15:0] = s_reg.length;
      sac_pkg::SEG_COUNT_OFS: rd_mux[15:0] = s_reg.seg_count;
      sac_pkg::AVG_COUNT_OFS: rd_mux[15:0] = s_reg.avg_count;
      sac_pkg::TIME_BASE_OFS: rd_mux[1:0] = s_reg.time_base;
      sac_pkg::STATUS_OFS: begin
        rd_mux[sac_pkg::STATUS_BUSY_BIT] = (s_reg.ph != PH_IDLE);
        rd_mux[sac_pkg::STATUS_DATA_BIT] = fifo_out_valid;
        rd_mux[sac_pkg::STATUS_SEG_POS +: 16] = s_reg.seg_idx;
      end
      sac_pkg::DATA_OFS: rd_mux = fifo_out_valid ? fifo_out_data : '0;
      sac_pkg::TRIG_STATE_OFS: begin
        rd_mux[1:0] = s_reg.stat_a;
        rd_mux[sac_pkg::TRIG_STATE_B_POS +: 2] = s_reg.stat_b;
      end
      default: addr_ok = 1'b0;
    endcase
    s_next.pready = 1'b0;
    s_next.pslverr = 1'b0;
    if (psel && penable && !s_reg.pready) begin
      s_next.pready = 1'b1;
      s_next.pslverr = !addr_ok;
      s_next.prdata = pwrite ? '0 : rd_mux;
      // Pop with the latch so an empty read never drops a later word
      if (!pwrite && paddr == sac_pkg::DATA_OFS) begin
        fifo_pop = 1'b1;
      end
    end
    if (psel && penable && s_reg.pready) begin
      if (pwrite) begin
        case (paddr)
          sac_pkg::CTRL_OFS: begin
            // A write in the same cycle as the self-clear wins
            s_next.ctrl.acq_en = pwdata[sac_pkg::CTRL_ACQ_EN_BIT];
            s_next.ctrl.single = pwdata[sac_pkg::CTRL_SINGLE_BIT];
            s_next.ctrl.trig_mode = pwdata[sac_pkg::CTRL_TRIG_MODE_BIT];
            s_next.ctrl.avg_en = pwdata[sac_pkg::CTRL_AVG_EN_BIT];
            s_next.ctrl.seg_en = pwdata[sac_pkg::CTRL_SEG_EN_BIT];
            s_next.sw_trig = pwdata[sac_pkg::CTRL_SW_TRIG_BIT];
          end
          sac_pkg::CH_CFG_OFS: begin
            for (int c = 0; c < N_CH; c++) begin
              s_next.ch_sel[c] = pwdata[c*sac_pkg::CH_CFG_STRIDE +: 6];
              s_next.ch_en[c] =
                pwdata[c*sac_pkg::CH_CFG_STRIDE + sac_pkg::CH_CFG_EN_BIT];
            end
          end
          sac_pkg::TRIG_SRC_OFS: s_next.trig_src = pwdata[10:0];
          sac_pkg::DELAY_OFS: s_next.delay = pwdata[15:0];
          sac_pkg::LENGTH_OFS: s_next.length = pwdata[15:0];
          sac_pkg::SEG_COUNT_OFS: s_next.seg_count = pwdata[15:0];
          sac_pkg::AVG_COUNT_OFS: s_next.avg_count = pwdata[15:0];
          sac_pkg::TIME_BASE_OFS: s_next.time_base = pwdata[1:0];
          default: begin
          end
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      s_reg <= '0;
      s_reg.length <= sac_pkg::LENGTH_RST;
      s_reg.seg_count <= sac_pkg::SEG_COUNT_RST;
      s_reg.avg_count <= sac_pkg::AVG_COUNT_RST;
      s_reg.time_base <= sac_pkg::TIME_BASE_2GHZ;
    end else begin
      s_reg <= s_next;
    end
  end
endmodule : sac_top

// *** tb/sac_top_checker.sv ***
module sac_top_checker (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic acq_active
);
  timeunit 1ns;
  timeprecision 1ps;
  // *****************
  // Bus and enable checks
  // *****************
  logic ctl_wr;
  assign ctl_wr = psel && penable && pready && pwrite &&
    paddr == sac_pkg::CTRL_OFS;
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  access_len_a: assert property (
    psel && $rose(penable) |-> !pready ##1 pready)
    else $error("access phase not two cycles");
  ready_cause_a: assert property (pready |-> psel && penable)
    else $error("pready outside access phase");
  err_with_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  err_rdata_a: assert property (
    pready && pslverr && !pwrite |-> prdata == 32'h0000_0000)
    else $error("refused read returned data");
  map_ok_a: assert property (
    pready && paddr <= 8'h28 && paddr[1:0] == 2'b00 |-> !pslverr)
    else $error("mapped access refused");
  enable_on_a: assert property (
    ctl_wr && pwdata[0] |-> ##[1:2] acq_active)
    else $error("enable write did not start acquisition");
  enable_off_a: assert property (
    ctl_wr && !pwdata[0] |-> ##[1:2] !acq_active)
    else $error("disable write ignored");
  start_cause_a: assert property (
    $rose(acq_active) |-> $past(ctl_wr) || $past(ctl_wr, 2))
    else $error("acquisition started without a write");
  reset_quiet_a: assert property (
    $rose(rstn) |-> !pready && !acq_active && prdata == 32'h0000_0000)
    else $error("outputs not cleared by reset");
  cover property (ctl_wr && pwdata[0]);
  cover property ($fell(acq_active) && !$past(ctl_wr));
  cover property (pready && pslverr);
endmodule : sac_top_checker

bind sac_top sac_top_checker i_sac_top_checker (.ref_clk, .rstn, .psel,
  .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
  .acq_active);

// *** tb/sac_far_model.sv ***
module sac_far_model (
  input wire logic ref_clk,
  input wire logic [15:0] base,
  input wire logic [5:0] lvl,
  input wire logic chatter,
  output logic [15:0] analyzer_signal_input,
  output logic [5:0][15:0] generator_output,
  output logic [5:0] trg
);
  timeunit 1ns;
  timeprecision 1ps;
  // *****************
  // Sample sources and trigger sources
  // *****************
  // trg: ext a, ext b, internal, seq out 1, seq out 2, seq monitor
  // Each generator output is offset so every selector code is distinct
  always @(posedge ref_clk) begin
    analyzer_signal_input <= base;
    for (int k = 0; k < 6; k++) begin
      generator_output[k] <= base + 16'((k + 1) * 4096);
    end
    trg[5:1] <= lvl[5:1];
    trg[0] <= chatter ? !trg[0] : lvl[0];
  end
endmodule : sac_far_model

// *** tb/sac_top_tb_top.sv ***
module sac_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [32:0] NIL = 33'h0_0000_0000;
  localparam logic [32:0] ONE = 33'h0_0000_0001;
  localparam logic [10:0] SRC[7] = '{sac_pkg::TRG_EXT_A,
    sac_pkg::TRG_EXT_B, sac_pkg::TRG_INTERNAL, sac_pkg::TRG_SEQ_OUT_1,
    sac_pkg::TRG_SEQ_OUT_2, sac_pkg::TRG_SEQ_MON, sac_pkg::TRG_SOFTWARE};
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, pslverr, acq_active;
  logic chatter = 1'b0;
  logic [15:0] ana, v;
  logic [15:0] base = 16'h0000;
  logic [5:0][15:0] gen;
  logic [5:0] lvl = 6'h00;
  logic [5:0] trg;
  int seed = 32'h0000_fe5b;
  int bad_count = 0;
  int checked = 0;
  logic [32:0] exp_q[$];

  sac_top #(.WINDOW_CYCLES(20)) i_sac_top (.ref_clk, .rstn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .analyzer_signal_input(ana), .generator_output(gen),
    .ext_trigger_a(trg[0]), .ext_trigger_b(trg[1]),
    .internal_trigger(trg[2]), .sequencer_trigger_out_1(trg[3]),
    .sequencer_trigger_out_2(trg[4]), .sequencer_monitor_trigger(trg[5]),
    .acq_active);
  sac_far_model i_sac_far_model (.ref_clk, .base, .lvl, .chatter,
    .analyzer_signal_input(ana), .generator_output(gen), .trg);

  // *****************
  // Bus tasks and scoreboard
  // *****************
  initial begin
    forever #12.5 ref_clk = ~ref_clk;
  end

  task automatic chk(input string nm, input logic [32:0] e,
    input logic [32:0] s);
    checked++;
    if (s !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for the answer
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    apb(1'b0, a, 32'h0000_0000);
  endtask : rd

  always @(posedge ref_clk) begin
    if (psel && penable && pready === 1'b1 && !pwrite &&
      exp_q.size() > 0) begin
      chk($sformatf("read %h", paddr), exp_q.pop_front(), {pslverr, prdata});
    end
  end

  task automatic drain(input int n, input logic [15:0] s);
    repeat (n) rd(sac_pkg::DATA_OFS, {1'b0, {16{s[15]}}, s});
    rd(sac_pkg::DATA_OFS, NIL);
  endtask : drain

  task automatic wait_idle;
    int n;
    n = 0;
    repeat (3) @(posedge ref_clk);
    while (acq_active !== 1'b0 && n < 3000) begin
      @(posedge ref_clk);
      n++;
    end
    chk("acq_active", NIL, {32'h0000_0000, acq_active});
    repeat (10) @(posedge ref_clk);
  endtask : wait_idle

  task automatic pulse(input int s);
    lvl <= 6'(1 << s);
    repeat (3) @(posedge ref_clk);
    lvl <= 6'h00;
  endtask : pulse

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    #1ms;
    bad_count++;
    tally_and_finish();
  end

  // *****************
  // Scenarios
  // *****************
  initial begin
    repeat (3) @(posedge ref_clk);
    rstn <= 1'b1;
    rd(sac_pkg::CTRL_OFS, NIL);
    rd(sac_pkg::LENGTH_OFS, {17'h0_0000, sac_pkg::LENGTH_RST});
    rd(sac_pkg::SEG_COUNT_OFS, {17'h0_0000, sac_pkg::SEG_COUNT_RST});
    rd(sac_pkg::AVG_COUNT_OFS, {17'h0_0000, sac_pkg::AVG_COUNT_RST});
    rd(sac_pkg::TIME_BASE_OFS, NIL);
    rd(8'h2C, 33'h1_0000_0000);
    v = 16'($random(seed));
    wr(sac_pkg::LENGTH_OFS, {16'($random(seed)), v});
    rd(sac_pkg::LENGTH_OFS, {17'h0_0000, v});
    wr(sac_pkg::LENGTH_OFS, 32'h0000_0003);
    for (int k = 0; k < 6; k++) begin
      base <= 16'($random(seed));
      wr(sac_pkg::CH_CFG_OFS, {16'h0000, 8'(8'hB0 + k), 8'h80});
      wr(sac_pkg::CTRL_OFS, 32'h0000_0001);
      wait_idle();
      repeat (3) rd(sac_pkg::DATA_OFS, {1'b0, {16{base[15]}}, base});
      drain(3, base + 16'((k + 1) * 4096));
    end
    wr(sac_pkg::CH_CFG_OFS, 32'h0000_3080);
    wr(sac_pkg::CTRL_OFS, 32'h0000_0001);
    wait_idle();
    drain(3, base);
    wr(sac_pkg::AVG_COUNT_OFS, 32'h0000_0003);
    wr(sac_pkg::CTRL_OFS, 32'h0000_0009);
    repeat (11) @(posedge ref_clk);
    chk("avg busy", ONE, {32'h0000_0000, acq_active});
    wait_idle();
    drain(3, base);
    wr(sac_pkg::LENGTH_OFS, 32'h0000_0014);
    wr(sac_pkg::SEG_COUNT_OFS, 32'h0000_0004);
    wr(sac_pkg::CTRL_OFS, 32'h0000_0011);
    wait_idle();
    drain(32, base);
    wr(sac_pkg::CTRL_OFS, 32'h0000_0013);
    wait_idle();
    rd(sac_pkg::STATUS_OFS, 33'h0_0000_0002);
    drain(8, base);
    wr(sac_pkg::SEG_COUNT_OFS, 32'h0000_0001);
    wr(sac_pkg::LENGTH_OFS, 32'h0000_0002);
    for (int i = 0; i < 7; i++) begin
      wr(sac_pkg::TRIG_SRC_OFS, {21'h00_0000, SRC[i]});
      wr(sac_pkg::CTRL_OFS, 32'h0000_0005);
      pulse((i + 1) % 6);
      repeat (10) @(posedge ref_clk);
      chk($sformatf("idle src %0d", i), ONE, {32'h0, acq_active});
      if (i < 6) pulse(i);
      else wr(sac_pkg::CTRL_OFS, 32'h0000_0025);
      wait_idle();
      drain(2, base);
    end
    wr(sac_pkg::TRIG_SRC_OFS, 32'h0000_0000);
    wr(sac_pkg::DELAY_OFS, 32'h0000_0028);
    v = base;
    wr(sac_pkg::CTRL_OFS, 32'h0000_0005);
    pulse(0);
    base <= ~v;
    wait_idle();
    drain(2, ~v);
    wr(sac_pkg::DELAY_OFS, 32'h0000_fff8);
    wr(sac_pkg::CTRL_OFS, 32'h0000_0005);
    base <= v;
    @(posedge ref_clk);
    pulse(0);
    wait_idle();
    drain(2, ~v);
    wr(sac_pkg::CTRL_OFS, 32'h0000_0005);
    wr(sac_pkg::CTRL_OFS, 32'h0000_0004);
    rd(sac_pkg::STATUS_OFS, NIL);
    lvl <= 6'h02;
    repeat (50) @(posedge ref_clk);
    rd(sac_pkg::TRIG_STATE_OFS, 33'h0_0000_0009);
    chatter <= 1'b1;
    repeat (50) @(posedge ref_clk);
    rd(sac_pkg::TRIG_STATE_OFS, 33'h0_0000_000B);
    tally_and_finish();
  end
endmodule : sac_top_tb_top
